// ===== sbst_cfg.svh
// Constants of the scan test port: lengths, capture values and reset values
`ifndef SBST_CFG_SVH
`define SBST_CFG_SVH

`define SBST_IR_LEN         3
`define SBST_ID_LEN         32
`define SBST_BS_LEN         109
`define SBST_IR_CAPTURE     3'h1
// Identification value is arbitrary; bit 0 stays set as a scan marker
`define SBST_ID_VALUE       32'h0000_0001
`define SBST_BYPASS_CAPTURE 1'h0
`define SBST_TCK_IDLE       1'h0
`define SBST_TMS_IDLE       1'h1
`define SBST_TDI_IDLE       1'h1

`endif

// ===== sbst_pkg.sv
// Types shared by the scan test port modules
package sbst_pkg;

  typedef enum logic [3:0] {
    SBST_TLR     = 4'h0,
    SBST_IDLE    = 4'h1,
    SBST_SEL_DR  = 4'h2,
    SBST_CAP_DR  = 4'h3,
    SBST_SH_DR   = 4'h4,
    SBST_EX1_DR  = 4'h5,
    SBST_PAU_DR  = 4'h6,
    SBST_EX2_DR  = 4'h7,
    SBST_UPD_DR  = 4'h8,
    SBST_SEL_IR  = 4'h9,
    SBST_CAP_IR  = 4'hA,
    SBST_SH_IR   = 4'hB,
    SBST_EX1_IR  = 4'hC,
    SBST_PAU_IR  = 4'hD,
    SBST_EX2_IR  = 4'hE,
    SBST_UPD_IR  = 4'hF
  } sbst_state_t;

  typedef enum logic [2:0] {
    SBST_EXTEST   = 3'h0,
    SBST_IDCODE   = 3'h1,
    SBST_SAMPLE_Z = 3'h2,
    SBST_RSVD3    = 3'h3,
    SBST_SAMPLE   = 3'h4,
    SBST_RSVD5    = 3'h5,
    SBST_RSVD6    = 3'h6,
    SBST_BYPASS   = 3'h7
  } sbst_instr_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_pins_t;

endpackage

// ===== sbst_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sbst_sync #(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_stable;

  // A bit moves only once stages two and three agree
  always_comb begin
    next_stable = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & stable);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1     <= INIT;
      s2     <= INIT;
      s3     <= INIT;
      stable <= INIT;
    end else begin
      s1     <= async;
      s2     <= s1;
      s3     <= s2;
      stable <= next_stable;
    end
  end

endmodule

`default_nettype wire

// ===== sbst_ctrl.sv
// Sixteen-state test controller stepped on test clock rising edges
`timescale 1ns/1ps
`default_nettype none

module sbst_ctrl (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               tckRise,
  input  wire logic               tms,
  output sbst_pkg::sbst_state_t   state
);
  import sbst_pkg::*;

  sbst_state_t next_state;

  always_comb begin
    next_state = state;
    if (tckRise) begin
      case (state)
        SBST_TLR:    next_state = tms ? SBST_TLR    : SBST_IDLE;
        SBST_IDLE:   next_state = tms ? SBST_SEL_DR : SBST_IDLE;
        SBST_SEL_DR: next_state = tms ? SBST_SEL_IR : SBST_CAP_DR;
        SBST_CAP_DR: next_state = tms ? SBST_EX1_DR : SBST_SH_DR;
        SBST_SH_DR:  next_state = tms ? SBST_EX1_DR : SBST_SH_DR;
        SBST_EX1_DR: next_state = tms ? SBST_UPD_DR : SBST_PAU_DR;
        SBST_PAU_DR: next_state = tms ? SBST_EX2_DR : SBST_PAU_DR;
        SBST_EX2_DR: next_state = tms ? SBST_UPD_DR : SBST_SH_DR;
        SBST_UPD_DR: next_state = tms ? SBST_SEL_DR : SBST_IDLE;
        SBST_SEL_IR: next_state = tms ? SBST_TLR    : SBST_CAP_IR;
        SBST_CAP_IR: next_state = tms ? SBST_EX1_IR : SBST_SH_IR;
        SBST_SH_IR:  next_state = tms ? SBST_EX1_IR : SBST_SH_IR;
        SBST_EX1_IR: next_state = tms ? SBST_UPD_IR : SBST_PAU_IR;
        SBST_PAU_IR: next_state = tms ? SBST_EX2_IR : SBST_PAU_IR;
        SBST_EX2_IR: next_state = tms ? SBST_UPD_IR : SBST_SH_IR;
        SBST_UPD_IR: next_state = tms ? SBST_SEL_DR : SBST_IDLE;
        default:     next_state = SBST_TLR;
      endcase
    end
  end

  // Power-up lands in Test-Logic-Reset; there is no separate test reset pin
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SBST_TLR;
    end else begin
      state <= next_state;
    end
  end

endmodule

`default_nettype wire

// ===== sbst_tap.sv
// Boundary-scan test access port of the memory: registers, decode and ball muxing
`timescale 1ns/1ps
`default_nettype none
`include "sbst_cfg.svh"

// Notes on behaviour
// - Registers: 3-bit instruction, 1-bit bypass, 32-bit identification, 109-cell chain.
// - Codes 000 extest, 001 ident, 010 sample-Z, 100 sample, 111 bypass.
// - Extest drives shifted vector on outputs and captures values at inputs.
// - Extest taking effect at instruction update drives preloaded values immediately.
// - Ident captures the fixed value, then shifts it between data in and out.
// - Ident instruction is loaded at power-up and in Test-Logic-Reset.
// - Sample-Z holds every memory output undriven.
// - Sample captures inputs and I/O states, then shifts the chain.
// - Asynchronous ball sampling may be unrepeatable but must do no harm.
// - Bypass shifts through the single bypass bit.
// - Output data register content is not preserved under extest.
// - No test reset pin; five high mode-select edges or power-up reset.
// - Inputs sampled on rising test clock edges, output changes on falling.
module sbst_tap #(
  parameter int                         BS_LEN   = `SBST_BS_LEN,
  parameter logic [`SBST_ID_LEN-1:0]    ID_VALUE = `SBST_ID_VALUE
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  tckPin,
  input  wire logic                  tmsPin,
  input  wire logic                  tdiPin,
  output logic                       tdo,
  output logic                       tdoOeN,
  input  wire logic [BS_LEN-1:0]     ballIn,
  input  wire logic [BS_LEN-1:0]     coreOut,
  input  wire logic                  coreOeN,
  output logic      [BS_LEN-1:0]     ballOut,
  output logic                       ballOeN,
  output sbst_pkg::sbst_state_t      tapState,
  output sbst_pkg::sbst_instr_t      activeInstr,
  output logic                       extestUsed,
  output logic                       scanUsed
);
  import sbst_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (BS_LEN < 2) begin : gBadLen
    $error("sbst_tap: boundary chain needs at least two cells");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Instructions that put the boundary chain in the scan path
  function automatic logic usesChain(input sbst_instr_t code);
    usesChain = (code == SBST_EXTEST) || (code == SBST_SAMPLE) ||
                (code == SBST_SAMPLE_Z);
  endfunction

  // Instructions whose update stage loads the chain's output latches
  function automatic logic loadsUpdate(input sbst_instr_t code);
    loadsUpdate = (code == SBST_EXTEST) || (code == SBST_SAMPLE);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sbst_pins_t          pinsRaw;
  sbst_pins_t          pins;
  logic [BS_LEN-1:0]   ballSync;
  logic                tckPrev;
  logic                tckRise;
  logic                tckFall;
  sbst_state_t         state;

  assign pinsRaw.tck = tckPin;
  assign pinsRaw.tms = tmsPin;
  assign pinsRaw.tdi = tdiPin;

  sbst_sync #(
    .WIDTH (3),
    .INIT  ({`SBST_TCK_IDLE, `SBST_TMS_IDLE, `SBST_TDI_IDLE})
  ) uPinSync (
    .clk    (clk),
    .rst    (rst),
    .async  (pinsRaw),
    .stable (pins)
  );

  // Ball values come from the memory clock domain; sampled values may still
  // be mid-transition when captured, which costs repeatability only
  sbst_sync #(
    .WIDTH (BS_LEN),
    .INIT  ('0)
  ) uBallSync (
    .clk    (clk),
    .rst    (rst),
    .async  (ballIn),
    .stable (ballSync)
  );

  // Edges are found on the filtered test clock only
  assign tckRise = pins.tck & ~tckPrev;
  assign tckFall = ~pins.tck & tckPrev;

  always_ff @(posedge clk) begin
    if (rst) begin
      tckPrev <= `SBST_TCK_IDLE;
    end else begin
      tckPrev <= pins.tck;
    end
  end

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  sbst_ctrl uCtrl (
    .clk     (clk),
    .rst     (rst),
    .tckRise (tckRise),
    .tms     (pins.tms),
    .state   (state)
  );

  assign tapState = state;

  // ----------------------------------------------------------------
  // Scan registers
  // ----------------------------------------------------------------
  sbst_instr_t                  instr;
  logic [`SBST_IR_LEN-1:0]      irShift;
  logic                         bypassBit;
  logic [`SBST_ID_LEN-1:0]      idShift;
  logic [BS_LEN-1:0]            bsShift;
  logic [BS_LEN-1:0]            bsUpdate;
  logic                         tdoBit;
  logic                         tdoOff;
  logic                         extestSeen;
  logic                         scanSeen;

  sbst_instr_t                  next_instr;
  logic [`SBST_IR_LEN-1:0]      next_irShift;
  logic                         next_bypassBit;
  logic [`SBST_ID_LEN-1:0]      next_idShift;
  logic [BS_LEN-1:0]            next_bsShift;
  logic [BS_LEN-1:0]            next_bsUpdate;
  logic                         next_tdoBit;
  logic                         next_tdoOff;
  logic                         next_extestSeen;
  logic                         next_scanSeen;

  logic                         shifting;
  logic                         shiftOut;

  assign shifting = (state == SBST_SH_IR) || (state == SBST_SH_DR);

  // Bit presented at the serial output; chain cell 1 sits at index 0
  always_comb begin
    if (state == SBST_SH_IR) begin
      shiftOut = irShift[0];
    end else if (usesChain(instr)) begin
      shiftOut = bsShift[0];
    end else if (instr == SBST_IDCODE) begin
      shiftOut = idShift[0];
    end else begin
      shiftOut = bypassBit;
    end
  end

  always_comb begin
    next_instr      = instr;
    next_irShift    = irShift;
    next_bypassBit  = bypassBit;
    next_idShift    = idShift;
    next_bsShift    = bsShift;
    next_bsUpdate   = bsUpdate;
    next_tdoBit     = tdoBit;
    next_tdoOff     = tdoOff;
    next_extestSeen = extestSeen | (instr == SBST_EXTEST);
    next_scanSeen   = scanSeen | (state != SBST_TLR);
    if (tckRise) begin
      case (state)
        SBST_TLR: begin
          next_instr = SBST_IDCODE;
        end
        SBST_SEL_IR: begin
          // Entering Test-Logic-Reset restores the identification code at once
          if (pins.tms) begin
            next_instr = SBST_IDCODE;
          end
        end
        SBST_CAP_IR: begin
          next_irShift = `SBST_IR_CAPTURE;
        end
        SBST_SH_IR: begin
          next_irShift = {pins.tdi, irShift[`SBST_IR_LEN-1:1]};
        end
        SBST_UPD_IR: begin
          // Reserved codes fall through to the bypass path below
          next_instr = sbst_instr_t'(irShift);
        end
        SBST_CAP_DR: begin
          if (usesChain(instr)) begin
            next_bsShift = ballSync;
          end else if (instr == SBST_IDCODE) begin
            next_idShift = ID_VALUE;
          end else begin
            next_bypassBit = `SBST_BYPASS_CAPTURE;
          end
        end
        SBST_SH_DR: begin
          if (usesChain(instr)) begin
            next_bsShift = {pins.tdi, bsShift[BS_LEN-1:1]};
          end else if (instr == SBST_IDCODE) begin
            next_idShift = {pins.tdi, idShift[`SBST_ID_LEN-1:1]};
          end else begin
            next_bypassBit = pins.tdi;
          end
        end
        SBST_UPD_DR: begin
          // Preload under sample fills the latches extest later drives
          if (loadsUpdate(instr)) begin
            next_bsUpdate = bsShift;
          end
        end
        default: begin
        end
      endcase
    end
    if (tckFall) begin
      next_tdoOff = ~shifting;
      if (shifting) begin
        next_tdoBit = shiftOut;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      instr      <= SBST_IDCODE;
      irShift    <= `SBST_IR_CAPTURE;
      bypassBit  <= `SBST_BYPASS_CAPTURE;
      idShift    <= '0;
      bsShift    <= '0;
      bsUpdate   <= '0;
      tdoBit     <= 1'h0;
      tdoOff     <= 1'h1;
      extestSeen <= 1'h0;
      scanSeen   <= 1'h0;
    end else begin
      instr      <= next_instr;
      irShift    <= next_irShift;
      bypassBit  <= next_bypassBit;
      idShift    <= next_idShift;
      bsShift    <= next_bsShift;
      bsUpdate   <= next_bsUpdate;
      tdoBit     <= next_tdoBit;
      tdoOff     <= next_tdoOff;
      extestSeen <= next_extestSeen;
      scanSeen   <= next_scanSeen;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Serial output moves five clocks after the pin falls, so the test clock's
  // low phase must outlast that if the far side samples at the next rise
  assign tdo         = tdoBit;
  assign tdoOeN      = tdoOff;
  assign activeInstr = instr;

  // Sticky until power-up reset: the memory must be reinitialised after
  // extest, and clock recovery rerun after any scan activity
  assign extestUsed  = extestSeen;
  assign scanUsed    = scanSeen;

  // The ball mux follows the live instruction, so extest drives the
  // preloaded latches from the very update that selects it
  always_comb begin
    case (instr)
      SBST_EXTEST: begin
        ballOut = bsUpdate;
        ballOeN = 1'h0;
      end
      SBST_SAMPLE_Z: begin
        ballOut = coreOut;
        ballOeN = 1'h1;
      end
      default: begin
        ballOut = coreOut;
        ballOeN = coreOeN;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== sbst_host.sv
// Scan controller model that drives the test pins of the port
`timescale 1ns/1ps
`default_nettype none
module sbst_host (
  input  wire logic clk,
  output logic      tckPin,
  output logic      tmsPin,
  output logic      tdiPin,
  input  wire logic tdo
);
  initial begin
    tckPin = 1'h0; // Test clock stands low between frames
    tmsPin = 1'h1;
    tdiPin = 1'h1; // Pulled-up line idles high
  end
  // One test clock period of 8 clk; mode and data held 4 clk each side of the rise
  task automatic step(input logic m, input logic d, output logic q);
    tmsPin <= m;
    tdiPin <= d;
    repeat (4) @(posedge clk);
    tckPin <= 1'h1;
    repeat (2) @(posedge clk);
    q = tdo;
    repeat (2) @(posedge clk);
    tckPin <= 1'h0;
  endtask
  task automatic reset5();
    logic q;
    repeat (5) step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    // Let the last rise pass the port's input filter before anyone looks
    repeat (6) @(posedge clk);
  endtask
  // Only the reserved-code check strays from the five defined codes
  task automatic scanIr(input logic [2:0] code, output logic [2:0] cap);
    logic q;
    step(1'h1, 1'h1, q);
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    step(1'h0, 1'h1, q);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], q);
      cap[i] = q;
    end
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    repeat (6) @(posedge clk);
  endtask
  // Bits past n come back as zero; first bit out is the captured cell 1
  task automatic scanDr(input int n, input logic [108:0] din, output logic [108:0] dout);
    logic q;
    dout = '0;
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    step(1'h0, 1'h1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'h1, 1'h1, q);
    step(1'h0, 1'h1, q);
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== sbst_tap_monitor.sv
// Concurrent checks on the ports of the scan test port
`timescale 1ns/1ps
`default_nettype none
module sbst_tap_monitor #(
  parameter int BS_LEN = 109
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  tckPin,
  input  wire logic                  tdo,
  input  wire logic                  tdoOeN,
  input  wire logic [BS_LEN-1:0]     coreOut,
  input  wire logic                  coreOeN,
  input  wire logic [BS_LEN-1:0]     ballOut,
  input  wire logic                  ballOeN,
  input  wire sbst_pkg::sbst_state_t tapState,
  input  wire sbst_pkg::sbst_instr_t activeInstr,
  input  wire logic                  extestUsed,
  input  wire logic                  scanUsed
);
  import sbst_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> tapState == SBST_TLR && activeInstr == SBST_IDCODE && !scanUsed; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_tlr; $past(tapState) == SBST_TLR && tapState != SBST_TLR |-> activeInstr == SBST_IDCODE; endproperty
  a_tlr: assert property (p_tlr) else $error("instruction not ident on leaving reset state");
  property p_shdr; $past(tapState) == SBST_SH_DR && tapState != SBST_SH_DR |-> tapState == SBST_EX1_DR; endproperty
  a_shdr: assert property (p_shdr) else $error("bad exit from data shift");
  property p_upd;
    $changed(activeInstr) |-> $past(tapState) inside {SBST_UPD_IR, SBST_SEL_IR, SBST_TLR};
  endproperty
  a_upd: assert property (p_upd) else $error("instruction changed outside update");
  property p_zoff; activeInstr == SBST_SAMPLE_Z |-> ballOeN; endproperty
  a_zoff: assert property (p_zoff) else $error("outputs driven under sample-Z");
  property p_exon; activeInstr == SBST_EXTEST |-> !ballOeN; endproperty
  a_exon: assert property (p_exon) else $error("outputs undriven under extest");
  property p_norm;
    !(activeInstr inside {SBST_EXTEST, SBST_SAMPLE_Z}) |-> ballOut == coreOut && ballOeN == coreOeN;
  endproperty
  a_norm: assert property (p_norm) else $error("ball path not normal");
  property p_tdo;
    $changed(tdo) |-> $past(tckPin, 6) && !$past(tckPin, 5) && !$past(tckPin, 2);
  endproperty
  a_tdo: assert property (p_tdo) else $error("serial out moved off falling edge");
  property p_oe; !tdoOeN |-> tapState inside {SBST_SH_DR, SBST_EX1_DR, SBST_SH_IR, SBST_EX1_IR}; endproperty
  a_oe: assert property (p_oe) else $error("serial out enabled outside shift");
  property p_ext; activeInstr == SBST_EXTEST |=> extestUsed; endproperty
  a_ext: assert property (p_ext) else $error("extest flag not set");
  property p_stk; extestUsed |=> extestUsed; endproperty
  a_stk: assert property (p_stk) else $error("extest flag lost");
  property p_scan; $past(tapState) == SBST_TLR && tapState != SBST_TLR |=> scanUsed; endproperty
  a_scan: assert property (p_scan) else $error("scan flag not set");
  property p_tlrid; tapState == SBST_TLR |-> activeInstr == SBST_IDCODE; endproperty
  a_tlrid: assert property (p_tlrid) else $error("instruction not ident in reset state");
endmodule
bind sbst_tap sbst_tap_monitor #(.BS_LEN(BS_LEN)) u_mon (.clk(clk), .rst(rst), .tckPin(tckPin),
  .tdo(tdo), .tdoOeN(tdoOeN), .coreOut(coreOut), .coreOeN(coreOeN), .ballOut(ballOut),
  .ballOeN(ballOeN), .tapState(tapState), .activeInstr(activeInstr), .extestUsed(extestUsed),
  .scanUsed(scanUsed));
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the scan test port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sbst_pkg::*;
  localparam logic [31:0] ID_VAL = 32'hA5C3_0F01; // Arbitrary identification value
  logic         clk = 1'h0;
  logic         rst, tck, tms, tdi, tdo, tdoOeN, coreOeN, ballOeN, extestUsed, scanUsed;
  logic [108:0] ballIn, coreOut, ballOut, got, vecA, vecB;
  logic [2:0]   cap;
  sbst_state_t  tapState;
  sbst_instr_t  activeInstr;
  sbst_instr_t  codes [4] = '{SBST_BYPASS, SBST_RSVD3, SBST_RSVD5, SBST_RSVD6};
  int           failCount = 0, numChecks = 0, cycles = 0;
  initial forever #20 clk = ~clk;
  sbst_tap #(.BS_LEN(109), .ID_VALUE(ID_VAL)) uut (.clk(clk), .rst(rst), .tckPin(tck),
    .tmsPin(tms), .tdiPin(tdi), .tdo(tdo), .tdoOeN(tdoOeN), .ballIn(ballIn), .coreOut(coreOut),
    .coreOeN(coreOeN), .ballOut(ballOut), .ballOeN(ballOeN), .tapState(tapState),
    .activeInstr(activeInstr), .extestUsed(extestUsed), .scanUsed(scanUsed));
  sbst_host host (.clk(clk), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi), .tdo(tdo));
  task automatic chk(input string nm, input logic [108:0] exp, input logic [108:0] act);
    numChecks++;
    if (act !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, act);
    end
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang counts as a mismatch; the whole run needs about 4700 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failCount++;
      completeRun();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'h1;
    coreOeN = 1'h0;
    ballIn = {1'h1, {27{4'h9}}};
    coreOut = {1'h0, {27{4'h3}}};
    vecA = {1'h0, {27{4'hC}}};
    vecB = {1'h1, {27{4'h5}}};
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (4) @(posedge clk);
    chk("state", SBST_TLR, tapState);
    chk("instr", SBST_IDCODE, activeInstr);
    host.reset5();
    host.scanDr(32, '0, got);
    chk("ident", ID_VAL, got);
    foreach (codes[k]) begin
      host.scanIr(codes[k], cap);
      chk("irCapture", 3'h1, cap);
      chk("instr", codes[k], activeInstr);
      host.scanDr(2, 109'h1, got);
      chk("bypass", 109'h2, got);
    end
    host.scanIr(SBST_SAMPLE_Z, cap);
    chk("oeSampleZ", 1'h1, ballOeN);
    host.scanDr(109, vecB, got);
    chk("captureZ", ballIn, got);
    host.scanIr(SBST_SAMPLE, cap);
    chk("ballOut", coreOut, ballOut);
    ballIn <= {1'h0, {27{4'h6}}};
    host.scanDr(109, vecA, got);
    chk("captureS", ballIn, got);
    host.scanIr(SBST_EXTEST, cap);
    chk("preload", vecA, ballOut);
    chk("oeExtest", 1'h0, ballOeN);
    ballIn <= {1'h1, {27{4'hE}}};
    host.scanDr(109, vecB, got);
    chk("captureX", ballIn, got);
    chk("applied", vecB, ballOut);
    host.scanIr(SBST_SAMPLE, cap);
    ballIn <= {1'h0, {27{4'h1}}};
    host.scanDr(60, vecA, got);
    chk("captureS", {49'h0, ballIn[59:0]}, got);
    host.scanIr(SBST_EXTEST, cap);
    chk("preload", {vecA[59:0], ballIn[108:60]}, ballOut);
    host.step(1'h1, 1'h1, cap[0]);
    host.step(1'h0, 1'h1, cap[0]);
    host.step(1'h0, 1'h1, cap[0]);
    host.reset5();
    chk("state", SBST_IDLE, tapState);
    chk("instr", SBST_IDCODE, activeInstr);
    chk("ballOut", coreOut, ballOut);
    chk("extestUsed", 1'h1, extestUsed);
    chk("scanUsed", 1'h1, scanUsed);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk("extestUsed", 1'h0, extestUsed);
    chk("scanUsed", 1'h0, scanUsed);
    chk("state", SBST_TLR, tapState);
    completeRun();
  end
endmodule
`default_nettype wire
